// [src/clhp_cfg.svh]
// constants of the character display host port and its glyph memory
`ifndef CLHP_CFG_SVH
`define CLHP_CFG_SVH
`define CLHP_CLK_NS 10
`define CLHP_CYC_NS 1000
`define CLHP_PW_NS 450
`define CLHP_SP_NS 60
`define CLHP_EXEC_NS 2000
`define CLHP_SP_CYC ((`CLHP_SP_NS + `CLHP_CLK_NS - 1) / `CLHP_CLK_NS)
`define CLHP_PW_CYC ((`CLHP_PW_NS + `CLHP_CLK_NS - 1) / `CLHP_CLK_NS)
`define CLHP_LOW_CYC ((`CLHP_CYC_NS - `CLHP_PW_NS - `CLHP_SP_NS + `CLHP_CLK_NS - 1) / `CLHP_CLK_NS)
`define CLHP_EXEC_CYC ((`CLHP_EXEC_NS + `CLHP_CLK_NS - 1) / `CLHP_CLK_NS)
`define CLHP_TEXT_DEPTH 80
`define CLHP_GLYPH_DEPTH 64
`define CLHP_FIFO_DEPTH 16
`define CLHP_FIFO_AW 4
`define CLHP_OP_W 10
`define CLHP_ROW_CUR8 4'h7
`define CLHP_ROW_CUR10 4'ha
`define CLHP_REG_CMD 8'h00
`define CLHP_REG_STAT 8'h04
`define CLHP_REG_RDATA 8'h08
`define CLHP_BIT_BUSY 7
`define CLHP_BIT_WIDE 4
`define CLHP_BIT_FONT 2
`define CLHP_BIT_CURSOR 1
`define CLHP_BIT_INC 1
`endif

// [src/clhp_pkg.sv]
// types shared by both ends of the character display host port
package clhp_pkg;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SETUP = 2'b01,
      H_HIGH = 2'b10,
      H_LOW = 2'b11
   } clhp_hstate_t;
   typedef logic [7:0] clhp_byte_t;
endpackage : clhp_pkg

// [src/clhp_bus_if.sv]
// parallel bus between the processor end and the display controller end
`timescale 1ns/1ps
interface clhp_bus_if;
   logic e;
   logic reg_select;
   logic rw;
   logic [7:0] host_db;
   logic host_oe_hi;
   logic host_oe_lo;
   logic [7:0] dev_db;
   logic dev_oe_hi;
   logic dev_oe_lo;
   wire [7:0] host_bus_lines;
   // undriven lines float high as if pulled up
   assign host_bus_lines[7:4] = host_oe_hi ? host_db[7:4] : (dev_oe_hi ? dev_db[7:4] : 4'hf);
   assign host_bus_lines[3:0] = host_oe_lo ? host_db[3:0] : (dev_oe_lo ? dev_db[3:0] : 4'hf);
   modport host (output e, output reg_select, output rw, output host_db, output host_oe_hi,
      output host_oe_lo, input host_bus_lines);
   modport dev (input e, input reg_select, input rw, input host_bus_lines, output dev_db,
      output dev_oe_hi, output dev_oe_lo);
endinterface : clhp_bus_if

// [src/clhp_dev_end.sv]
// display controller end: command and ram data registers, ram pointer, glyph memory
`timescale 1ns/1ps
`include "clhp_cfg.svh"

// Function
// - narrow bus uses only upper four lines
// - narrow byte: high nibble first, low second
// - wide bus: whole byte in one transfer
// - write selects command or ram data word
// - status read: busy bit7, pointer bits 0-6
// - command word is never readable
// - instructions ignored while busy; host polls first
// - address command loads the ram pointer
// - pointer steps after each ram access
// - upper code nibble zero selects glyph ram
// - 5x8: code bits 0-2 pick glyph
// - 5x8: row bits 0-2, row 7 cursor OR
// - 5x10: code bits 1-2 pick glyph
// - 5x10: row bits 0-3, row 10 cursor OR
// - only low five pattern bits lit
// - undisplayed glyph rows stay readable and writable
// - cursor at text address equal to pointer
// - function set with width bit clear: narrow
module clhp_dev_end
   import clhp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // processor bus
   clhp_bus_if.dev bus,
   // display scan side
   input wire logic [7:0] scan_code,
   input wire logic [3:0] scan_row,
   input wire logic [6:0] scan_addr,
   output logic [4:0] pix_bits,
   output logic from_glyph_ram,
   output logic cursor_here,
   // mode view
   output logic narrow_mode,
   output logic busy_indicator
);
   // -----------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------
   logic [10:0] pin_raw;
   logic [10:0] pin_s1;
   logic [10:0] pin_s2;
   logic [10:0] pin_s3;
   logic [10:0] pin_f;
   assign pin_raw = {bus.e, bus.reg_select, bus.rw, bus.host_bus_lines};

   // a pin level counts only once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            pin_s1[gi] <= pin_raw[gi];
            pin_s2[gi] <= pin_s1[gi];
            pin_s3[gi] <= pin_s2[gi];
            if (rst) begin
               pin_f[gi] <= 1'b0;
            end else if (pin_s2[gi] == pin_s3[gi]) begin
               pin_f[gi] <= pin_s3[gi];
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------
   // strobe decode
   // -----------------------------------------------------------
   logic e_q;
   wire e_f = pin_f[10];
   wire rs_f = pin_f[9];
   wire rw_f = pin_f[8];
   wire [7:0] db_f = pin_f[7:0];
   wire e_rise = e_f & ~e_q;
   wire e_fall = e_q & ~e_f;

   logic phase;
   logic [3:0] hi_nib;
   logic [6:0] ram_pointer;
   logic to_glyph;
   logic inc_dir;
   logic five_by_ten;
   logic cursor_on;
   logic [7:0] command_word;
   logic [7:0] ram_data_word;
   logic [7:0] rd_byte;
   logic [7:0] busy_cnt;
   logic [7:0] text_ram [0:`CLHP_TEXT_DEPTH-1];
   logic [7:0] glyph_ram [0:`CLHP_GLYPH_DEPTH-1];

   // byte assembled from one wide or two narrow strobes
   wire [7:0] byte_in = narrow_mode ? {hi_nib, db_f[7:4]} : db_f;
   wire last_nib = ~narrow_mode | phase;
   wire done = e_fall & last_nib;
   wire is_busy = busy_cnt != 8'h00;
   wire wr_cmd = done & ~rw_f & ~rs_f & ~is_busy;
   wire wr_data = done & ~rw_f & rs_f;
   wire rd_data = done & rw_f & rs_f;
   wire is_fset = byte_in[7:5] == 3'b001;
   wire is_entry = byte_in[7:2] == 6'b000001;
   wire is_disp = byte_in[7:3] == 5'b00001;
   wire is_gaddr = byte_in[7:6] == 2'b01;
   wire is_taddr = byte_in[7];
   wire [6:0] ptr_step = inc_dir ? ram_pointer + 7'h01 : ram_pointer - 7'h01;
   wire text_ok = ram_pointer < 7'(`CLHP_TEXT_DEPTH);
   wire [7:0] ram_rd = to_glyph ? glyph_ram[ram_pointer[5:0]] : (text_ok ? text_ram[ram_pointer] : 8'h00);

   // -----------------------------------------------------------
   // nibble phase and width mode
   // -----------------------------------------------------------
   // phase advances on every narrow strobe, reads and writes alike
   always_ff @(posedge mclk) begin
      if (rst) begin
         e_q <= 1'b0;
         phase <= 1'b0;
         hi_nib <= 4'h0;
      end else begin
         e_q <= e_f;
         if (e_fall & narrow_mode) begin
            phase <= ~phase;
            if (~phase) begin
               hi_nib <= db_f[7:4];
            end
         end
      end
   end

   // instruction execution; a command arriving while busy is dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         narrow_mode <= 1'b0;
         five_by_ten <= 1'b0;
         inc_dir <= 1'b1;
         cursor_on <= 1'b0;
         command_word <= 8'h00;
      end else if (wr_cmd) begin
         command_word <= byte_in;
         if (is_fset) begin
            narrow_mode <= ~byte_in[`CLHP_BIT_WIDE];
            five_by_ten <= byte_in[`CLHP_BIT_FONT];
         end
         if (is_entry) begin
            inc_dir <= byte_in[`CLHP_BIT_INC];
         end
         if (is_disp) begin
            cursor_on <= byte_in[`CLHP_BIT_CURSOR];
         end
      end
   end

   // pointer: loaded by address commands, stepped by ram traffic
   always_ff @(posedge mclk) begin
      if (rst) begin
         ram_pointer <= 7'h00;
         to_glyph <= 1'b0;
      end else if (wr_cmd & is_taddr) begin
         ram_pointer <= byte_in[6:0];
         to_glyph <= 1'b0;
      end else if (wr_cmd & is_gaddr) begin
         ram_pointer <= {1'b0, byte_in[5:0]};
         to_glyph <= 1'b1;
      end else if (wr_data | rd_data) begin
         ram_pointer <= ptr_step;
      end
   end

   // busy lasts a fixed execution time after each accepted write
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_cnt <= 8'h00;
      end else if (wr_cmd | wr_data) begin
         busy_cnt <= 8'(`CLHP_EXEC_CYC);
      end else if (is_busy) begin
         busy_cnt <= busy_cnt - 8'h01;
      end
   end

   // ram writes; every glyph row is kept, displayed or not
   always_ff @(posedge mclk) begin
      if (wr_data) begin
         if (to_glyph) begin
            glyph_ram[ram_pointer[5:0]] <= byte_in;
         end else if (text_ok) begin
            text_ram[ram_pointer] <= byte_in;
         end
      end
   end

   // -----------------------------------------------------------
   // read path
   // -----------------------------------------------------------
   // latched once per byte so both nibbles come from one snapshot
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_byte <= 8'h00;
         ram_data_word <= 8'h00;
      end else begin
         if (e_rise & rw_f & (~narrow_mode | ~phase)) begin
            rd_byte <= rs_f ? ram_rd : {is_busy, ram_pointer};
         end
         if (wr_data) begin
            ram_data_word <= byte_in;
         end else if (e_rise & rw_f & rs_f & (~narrow_mode | ~phase)) begin
            ram_data_word <= ram_rd;
         end
      end
   end

   // lane steering: narrow reads put each nibble on the upper lines
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.dev_db <= 8'h00;
         bus.dev_oe_hi <= 1'b0;
         bus.dev_oe_lo <= 1'b0;
         busy_indicator <= 1'b0;
      end else begin
         bus.dev_db <= narrow_mode ? {(phase ? rd_byte[3:0] : rd_byte[7:4]), 4'h0} : rd_byte;
         bus.dev_oe_hi <= e_f & rw_f;
         bus.dev_oe_lo <= e_f & rw_f & ~narrow_mode;
         busy_indicator <= is_busy;
      end
   end

   // -----------------------------------------------------------
   // glyph scan
   // -----------------------------------------------------------
   wire glyph_hit = scan_code[7:4] == 4'h0;
   wire [5:0] g_addr = five_by_ten ? {scan_code[2:1], scan_row}
      : {scan_code[2:0], scan_row[2:0]};
   wire cur_row = scan_row == (five_by_ten ? `CLHP_ROW_CUR10 : `CLHP_ROW_CUR8);
   wire cur_pos = scan_addr == ram_pointer;
   wire [4:0] cur_mask = (cursor_on & cur_row & cur_pos) ? 5'h1f : 5'h00;

   // pattern row ORed with cursor; upper three bits never shown
   always_ff @(posedge mclk) begin
      if (rst) begin
         pix_bits <= 5'h00;
         from_glyph_ram <= 1'b0;
         cursor_here <= 1'b0;
      end else begin
         pix_bits <= (glyph_hit ? glyph_ram[g_addr][4:0] : 5'h00) | cur_mask;
         from_glyph_ram <= glyph_hit;
         cursor_here <= cur_pos;
      end
   end
endmodule : clhp_dev_end

// [src/clhp_host_end.sv]
// processor end: command fifo, strobe sequencer with busy polling, register port
`timescale 1ns/1ps
`include "clhp_cfg.svh"

// -----------------------------------------------------------
// command fifo
// -----------------------------------------------------------
module clhp_fifo #(
   parameter int WIDTH = `CLHP_OP_W,
   parameter int DEPTH = `CLHP_FIFO_DEPTH,
   parameter int AW = `CLHP_FIFO_AW
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW:0] next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data = mem[rp];

   // full and empty kept as flops so the ready seen outside is clean
   always_ff @(posedge mclk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wp <= wp + AW'(push);
         rp <= rp + AW'(pop);
         cnt <= next_cnt;
         in_ready <= next_cnt != (AW+1)'(DEPTH);
         out_valid <= next_cnt != '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
endmodule : clhp_fifo

// -----------------------------------------------------------
// host end
// -----------------------------------------------------------
module clhp_host_end
   import clhp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic cmd_ready,
   // processor bus
   clhp_bus_if.host bus
);
   // data lines pass three stages; second and third must agree
   logic [7:0] db_s1;
   logic [7:0] db_s2;
   logic [7:0] db_s3;
   logic [7:0] db_f;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            db_s1[gi] <= bus.host_bus_lines[gi];
            db_s2[gi] <= db_s1[gi];
            db_s3[gi] <= db_s2[gi];
            if (rst) begin
               db_f[gi] <= 1'b0;
            end else if (db_s2[gi] == db_s3[gi]) begin
               db_f[gi] <= db_s3[gi];
            end
         end
      end
   endgenerate

   clhp_hstate_t state;
   logic [7:0] tmr;
   logic poll;
   logic nib;
   logic narrow;
   logic op_rs;
   logic op_rw;
   clhp_byte_t op_b;
   clhp_byte_t rx;
   clhp_byte_t last_rd;
   logic rd_valid;
   logic f_valid;
   logic f_ready;
   logic [`CLHP_OP_W-1:0] f_data;

   // -----------------------------------------------------------
   // register decode
   // -----------------------------------------------------------
   wire sel_cmd = wr & (addr == `CLHP_REG_CMD);
   wire sel_stat = rd & (addr == `CLHP_REG_STAT);
   wire sel_rdata = rd & (addr == `CLHP_REG_RDATA);
   wire [15:0] stat_word = {11'h000, state != H_IDLE, narrow, ~cmd_ready, ~f_valid, rd_valid};
   wire [15:0] rd_mux = sel_stat ? stat_word : (sel_rdata ? {8'h00, last_rd} : 16'h0000);

   clhp_fifo #(.WIDTH(`CLHP_OP_W), .DEPTH(`CLHP_FIFO_DEPTH), .AW(`CLHP_FIFO_AW)) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(sel_cmd),
      .in_ready(f_ready),
      .in_data(wdata[`CLHP_OP_W-1:0]),
      .out_valid(f_valid),
      .out_ready(state == H_IDLE),
      .out_data(f_data)
   );
   // ready straight from the fifo flop, so a push right after filling sees it low at once
   assign cmd_ready = f_ready;

   // -----------------------------------------------------------
   // strobe sequencer
   // -----------------------------------------------------------
   wire tdone = tmr == 8'h00;
   wire last_nib = ~narrow | nib;
   wire cur_rs = ~poll & op_rs;
   wire cur_rw = poll | op_rw;
   wire [7:0] cur_lane = narrow ? {(nib ? op_b[3:0] : op_b[7:4]), 4'h0} : op_b;
   wire [7:0] rx_next = narrow ? (nib ? {rx[7:4], db_f[7:4]} : {db_f[7:4], rx[3:0]}) : db_f;

   // every op is preceded by busy polls until bit 7 reads clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= H_IDLE;
         tmr <= 8'h00;
         poll <= 1'b0;
         nib <= 1'b0;
         rx <= 8'h00;
      end else begin
         tmr <= tdone ? 8'h00 : tmr - 8'h01;
         unique case (state)
            H_IDLE: if (f_valid) begin
               poll <= 1'b1;
               state <= H_SETUP;
               tmr <= 8'(`CLHP_SP_CYC);
            end
            H_SETUP: if (tdone) begin
               state <= H_HIGH;
               tmr <= 8'(`CLHP_PW_CYC);
            end
            H_HIGH: if (tdone) begin
               rx <= rx_next;
               state <= H_LOW;
               tmr <= 8'(`CLHP_LOW_CYC);
            end
            H_LOW: if (tdone) begin
               nib <= ~last_nib;
               if (~last_nib | (poll & rx[`CLHP_BIT_BUSY])) begin
                  state <= H_SETUP;
                  tmr <= 8'(`CLHP_SP_CYC);
               end else if (poll) begin
                  poll <= 1'b0;
                  state <= H_SETUP;
                  tmr <= 8'(`CLHP_SP_CYC);
               end else begin
                  state <= H_IDLE;
               end
            end
         endcase
      end
   end

   // op latch, width tracking and read result
   always_ff @(posedge mclk) begin
      if (rst) begin
         {op_rs, op_rw, op_b} <= 10'h000;
         narrow <= 1'b0;
         last_rd <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         if (state == H_IDLE & f_valid) begin
            {op_rs, op_rw, op_b} <= f_data;
         end
         if (state == H_LOW & tdone & last_nib & ~poll) begin
            if (~op_rs & ~op_rw & op_b[7:5] == 3'b001) begin
               narrow <= ~op_b[`CLHP_BIT_WIDE];
            end
         end
         // a completing read wins over a clear in the same cycle
         if (state == H_LOW & tdone & last_nib & ~poll & op_rw) begin
            last_rd <= rx;
            rd_valid <= 1'b1;
         end else if (sel_rdata) begin
            rd_valid <= 1'b0;
         end
      end
   end

   // pin drive, one cycle behind the sequencer state
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.e <= 1'b0;
         bus.reg_select <= 1'b0;
         bus.rw <= 1'b1;
         bus.host_db <= 8'h00;
         bus.host_oe_hi <= 1'b0;
         bus.host_oe_lo <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         bus.e <= state == H_HIGH;
         bus.reg_select <= cur_rs;
         bus.rw <= cur_rw;
         bus.host_db <= cur_lane;
         bus.host_oe_hi <= (state != H_IDLE) & ~cur_rw;
         bus.host_oe_lo <= (state != H_IDLE) & ~cur_rw & ~narrow;
         rdata <= rd_mux;
      end
   end
endmodule : clhp_host_end

// [dv/clhp_bus_properties.sv]
// concurrent checks on the processor bus between the two ends
`timescale 1ns/1ps
module clhp_bus_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // processor bus signals
   input wire logic e,
   input wire logic reg_select,
   input wire logic rw,
   input wire logic [7:0] host_db,
   input wire logic host_oe_hi,
   input wire logic host_oe_lo,
   input wire logic [7:0] dev_db,
   input wire logic dev_oe_hi,
   input wire logic dev_oe_lo,
   input wire logic [7:0] host_bus_lines
);
   // ------------------------------
   // bus properties
   // ------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // a read strobe starts, then the device must answer on the upper lines
   sequence s_read_rise;
      $rose(e) && rw;
   endsequence
   sequence s_dev_answer;
      ##[1:10] dev_oe_hi;
   endsequence

   a_no_contention: assert property (!((host_oe_hi && dev_oe_hi) || (host_oe_lo && dev_oe_lo)))
      else $error("both ends drive the data lines");
   a_read_host_off: assert property (e && rw |-> !host_oe_hi && !host_oe_lo)
      else $error("host drives lines during a read");
   a_dev_only_reads: assert property (dev_oe_hi || dev_oe_lo |-> rw)
      else $error("device drives lines during a write");
   a_low_needs_high: assert property ((!host_oe_lo || host_oe_hi) && (!dev_oe_lo || dev_oe_hi))
      else $error("lower lines driven without upper lines");
   a_select_held: assert property (e && $past(e) |-> $stable(reg_select) && $stable(rw))
      else $error("select or direction moved inside a strobe");
   a_write_nibble_held: assert property (e && $past(e) && !rw |-> host_oe_hi && $stable(host_db[7:4]))
      else $error("write data not held through the strobe");
   a_read_answer: assert property (s_read_rise |-> s_dev_answer)
      else $error("device did not drive read data");
   a_read_on_wire: assert property (dev_oe_hi |-> host_bus_lines[7:4] == dev_db[7:4])
      else $error("read data missing from the wire");
   a_dev_release: assert property ($fell(e) |-> ##[1:10] (!dev_oe_hi && !dev_oe_lo))
      else $error("device kept the lines after the strobe");
   a_strobe_width: assert property ($rose(e) |=> e [*8])
      else $error("strobe pulse too short");
   a_strobe_gap: assert property ($fell(e) |=> !e [*8])
      else $error("strobes too close together");
endmodule : clhp_bus_properties

// [dv/clhp_tb_top.sv]
// self-checking bench: register port stimulus, wire log and scan side checks
`timescale 1ns/1ps
module clhp_tb_top
   import clhp_pkg::*;
;
   // ------------------------------
   // signals and instances
   // ------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic cmd_ready;
   logic [7:0] scan_code = 8'h00;
   logic [3:0] scan_row = 4'h0;
   logic [6:0] scan_addr = 7'h7f;
   logic [4:0] pix_bits;
   logic from_glyph_ram, cursor_here, narrow_mode, busy_indicator;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   clhp_byte_t g [64];
   logic [7:0] wq [$];
   logic [15:0] s;
   clhp_bus_if i_clhp_bus_if ();
   clhp_host_end i_clhp_host_end (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cmd_ready(cmd_ready), .bus(i_clhp_bus_if.host));
   clhp_dev_end i_clhp_dev_end (.mclk(mclk), .rst(rst), .bus(i_clhp_bus_if.dev), .scan_code(scan_code),
      .scan_row(scan_row), .scan_addr(scan_addr), .pix_bits(pix_bits), .from_glyph_ram(from_glyph_ram),
      .cursor_here(cursor_here), .narrow_mode(narrow_mode), .busy_indicator(busy_indicator));
   clhp_bus_properties i_clhp_bus_properties (.mclk(mclk), .rst(rst), .e(i_clhp_bus_if.e),
      .reg_select(i_clhp_bus_if.reg_select), .rw(i_clhp_bus_if.rw), .host_db(i_clhp_bus_if.host_db),
      .host_oe_hi(i_clhp_bus_if.host_oe_hi), .host_oe_lo(i_clhp_bus_if.host_oe_lo),
      .dev_db(i_clhp_bus_if.dev_db), .dev_oe_hi(i_clhp_bus_if.dev_oe_hi), .dev_oe_lo(i_clhp_bus_if.dev_oe_lo),
      .host_bus_lines(i_clhp_bus_if.host_bus_lines));

   always #5 mclk = ~mclk;

   // hang guard, well above the expected run of about 50k cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         end_of_test();
      end
   end

   // log each ram data write as seen on the wire at the strobe fall
   always @(negedge i_clhp_bus_if.e) begin
      if (i_clhp_bus_if.reg_select && !i_clhp_bus_if.rw) begin
         wq.push_back(i_clhp_bus_if.host_bus_lines);
      end
   end

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
      check_count++;
      if (got !== ex) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, ex, got);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic push(input logic [9:0] op);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         #1 n++;
      end
      wr_reg(8'h00, {6'h00, op});
   endtask : push

   // wait until the fifo is empty and the strobe engine has stopped
   task automatic idle();
      int n;
      n = 0;
      do begin
         rd_reg(8'h04, s);
         n++;
      end while ((s[4] !== 1'b0 || s[1] !== 1'b1) && n < 20000);
   endtask : idle

   task automatic rdop(input logic rs, output logic [7:0] d);
      push({rs, 1'b1, 8'h00});
      idle();
      rd_reg(8'h08, s);
      d = s[7:0];
   endtask : rdop

   task automatic scan(input logic [7:0] c, input logic [3:0] r, input logic [6:0] a, input logic [4:0] ex,
      input logic cur);
      @(posedge mclk);
      scan_code <= c;
      scan_row <= r;
      scan_addr <= a;
      repeat (2) @(posedge mclk);
      #1;
      chk("from_glyph_ram", {15'h0000, c[7:4] == 4'h0}, {15'h0000, from_glyph_ram});
      chk("cursor_here", {15'h0000, cur}, {15'h0000, cursor_here});
      if (c[7:4] == 4'h0) begin
         chk("pix_bits", {11'h000, ex}, {11'h000, pix_bits});
      end
   endtask : scan

   // expected lit pixels from code, row and font through the glyph address map
   function automatic logic [4:0] exp_px(input logic [7:0] c, input logic [3:0] r, input logic tall);
      return tall ? g[{c[2:1], r}][4:0] : g[{c[2:0], r[2:0]}][4:0];
   endfunction : exp_px

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      logic [7:0] b;
      logic [7:0] c;
      logic [3:0] r;
      void'($urandom(32'h255e3806));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(8'h04, s);
      chk("stat_reset", 16'h0002, s);
      rd_reg(8'h0c, s);
      chk("unmapped", 16'h0000, s);
      // wide stream of glyph bytes; the fifo fills and one push while full is dropped
      push(10'h030);
      push(10'h040);
      for (int i = 0; i < 64; i++) begin
         g[i] = clhp_byte_t'($urandom);
         push({2'b10, g[i]});
         if (i == 20) begin
            rd_reg(8'h04, s);
            chk("fifo_full", 16'h0001, {15'h0000, s[2] & ~cmd_ready});
            wr_reg(8'h00, 16'h02ee);
         end
      end
      idle();
      chk("wire_count", 16'd64, 16'(wq.size()));
      for (int i = 0; i < 64; i++) chk("wire_byte", {8'h00, g[i]}, {8'h00, wq[i]});
      push(10'h040);
      for (int i = 0; i < 64; i++) begin
         rdop(1'b1, b);
         chk("glyph_read", {8'h00, g[i]}, {8'h00, b});
      end
      // pointer load, status read and stepping
      push(10'h045);
      rdop(1'b0, b);
      chk("status", 16'h0005, {8'h00, b});
      rdop(1'b1, b);
      chk("data_at_ptr", {8'h00, g[5]}, {8'h00, b});
      rdop(1'b1, b);
      rdop(1'b0, b);
      chk("status_step", 16'h0007, {8'h00, b});
      // scan side, 5x8 font then tall 5x10 font
      for (int k = 0; k < 12; k++) begin
         c = {($urandom_range(2) == 0) ? 4'h5 : 4'h0, 4'($urandom)};
         r = 4'($urandom_range(7));
         scan(c, r, 7'h7f, exp_px(c, r, 1'b0), 1'b0);
      end
      push(10'h034);
      idle();
      for (int k = 0; k < 12; k++) begin
         c = {4'h0, 4'($urandom)};
         r = 4'($urandom_range(10));
         scan(c, r, 7'h7f, exp_px(c, r, 1'b1), 1'b0);
      end
      // cursor on at text address 7, then decrement entry
      push(10'h00e);
      push(10'h087);
      idle();
      scan(8'h0b, 4'ha, 7'h07, g[{2'b01, 4'ha}][4:0] | 5'h1f, 1'b1);
      scan(8'h0b, 4'ha, 7'h08, g[{2'b01, 4'ha}][4:0], 1'b0);
      push(10'h004);
      push(10'h241);
      rdop(1'b0, b);
      chk("status_dec", 16'h0086 & 16'h007f, {8'h00, b});
      push(10'h087);
      rdop(1'b1, b);
      chk("text_read", 16'h0041, {8'h00, b});
      // four-line operation, nibble order on the wire
      push(10'h006);
      push(10'h020);
      idle();
      chk("narrow_mode", 16'h0001, {15'h0000, narrow_mode});
      chk("stat_narrow", 16'h0001, {15'h0000, s[3]});
      // the function set has just executed, so busy still stands; it clears after its execution time
      chk("busy_set", 16'h0001, {15'h0000, busy_indicator});
      repeat (200) @(posedge mclk);
      #1;
      chk("busy_clear", 16'h0000, {15'h0000, busy_indicator});
      wq.delete();
      push(10'h050);
      push(10'h2a5);
      push(10'h23c);
      push(10'h050);
      rdop(1'b1, b);
      chk("narrow_rd0", 16'h00a5, {8'h00, b});
      rdop(1'b1, b);
      chk("narrow_rd1", 16'h003c, {8'h00, b});
      rdop(1'b0, b);
      chk("narrow_status", 16'h0012, {8'h00, b});
      chk("nibble_count", 16'd4, 16'(wq.size()));
      chk("nibbles", 16'haf5f, {wq[0], wq[1]});
      chk("nibbles", 16'h3fcf, {wq[2], wq[3]});
      end_of_test();
   end
endmodule : clhp_tb_top
